// [crem_pkg.sv]
// Package for the receive-side link event monitor: event codes, unit-mask fields, widths.
// Assumes a single 100 MHz core clock and flit descriptors from the link receiver.
`default_nettype none
package crem_pkg;
  localparam int          CNT_W          = 48;
  localparam int          NUM_CNT        = 4;
  localparam logic [7:0]  EV_VN1_CREDIT  = 8'h39;
  localparam logic [7:0]  EV_ADAPT_CRED  = 8'h1D;
  localparam logic [7:0]  EV_QUEUE_NE    = 8'h0A;
  localparam logic [7:0]  EV_FLIT_G0     = 8'h01;
  localparam logic [7:0]  EV_FLIT_G1     = 8'h02;
  localparam logic [1:0]  MAX_INC_TWO    = 2'h2;
  localparam logic [1:0]  MAX_INC_ONE    = 2'h1;
  // Unit-mask bit positions for credit classes
  localparam int          UM_DRS         = 0;
  localparam int          UM_NCB         = 1;
  localparam int          UM_NCS         = 2;
  localparam int          UM_HOM         = 3;
  localparam int          UM_SNP         = 4;
  localparam int          UM_NDR         = 5;
  // Group 0 unit-mask bits
  localparam int          UM_G0_IDLE     = 0;
  localparam int          UM_G0_DATA     = 1;
  localparam int          UM_G0_NONDATA  = 2;
  // Group 1 unit-mask bits
  localparam int          UM_G1_SNP      = 0;
  localparam int          UM_G1_HOMREQ   = 1;
  localparam int          UM_G1_HOMNREQ  = 2;
  localparam int          UM_G1_DRSDATA  = 3;
  localparam int          UM_G1_DRSHDR   = 4;
  // Flit kind and message class encodings on the receive ports
  typedef enum logic [1:0] {
    CREM_FLIT_IDLE,
    CREM_FLIT_HDR,
    CREM_FLIT_DATA,
    CREM_FLIT_PROT
  } crem_kind_e;
  typedef enum logic [2:0] {
    CREM_CLS_DRS,
    CREM_CLS_NCB,
    CREM_CLS_NCS,
    CREM_CLS_HOM,
    CREM_CLS_SNP,
    CREM_CLS_NDR
  } crem_cls_e;
endpackage
`default_nettype wire

// [crem_counter.sv]
// One event counter: adds a capped increment while enabled, cleared on request.
// Assumes increment and controls are registered in the core clock domain.
`default_nettype none
module crem_counter
  import crem_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic [1:0]       inc,
  output logic      [CNT_W-1:0] count
);
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(inc);
    end
  end
endmodule
`default_nettype wire

// [crem_monitor.sv]
// Receive-side link event monitor: selects flit and credit events and drives four counters.
// Assumes flit descriptors arrive two lanes per cycle, synchronous to core_clk, from the link receiver.
`default_nettype none
module crem_monitor
  import crem_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic [1:0]               rx_flit_valid,
  input  wire logic [3:0]               rx_flit_kind,
  input  wire logic [5:0]               rx_flit_class,
  input  wire logic [1:0]               rx_flit_is_req,
  input  wire logic [1:0]               rx_vnet1_credit_used,
  input  wire logic [5:0]               rx_vnet1_credit_class,
  input  wire logic                     rx_adaptive_credit_used,
  input  wire logic                     receive_flit_queue_nonempty,
  input  wire logic [NUM_CNT*8-1:0]     cnt_event_sel,
  input  wire logic [NUM_CNT*8-1:0]     cnt_unit_mask,
  input  wire logic [NUM_CNT-1:0]       cnt_enable,
  input  wire logic [NUM_CNT-1:0]       cnt_clear,
  output logic      [NUM_CNT*CNT_W-1:0] cnt_value,
  output logic      [NUM_CNT-1:0]       cnt_bad_event_r
);

  // Does one flit lane match the group-zero mask
  function automatic logic g0_hit(input logic [1:0] kind, input logic [7:0] um);
    logic hit;
    hit = 1'b0;
    if (um[UM_G0_IDLE] && kind == CREM_FLIT_IDLE) hit = 1'b1;
    if (um[UM_G0_DATA] && kind == CREM_FLIT_DATA) hit = 1'b1;
    if (um[UM_G0_NONDATA] && (kind == CREM_FLIT_HDR || kind == CREM_FLIT_PROT)) hit = 1'b1;
    return hit;
  endfunction

  // Does one flit lane match the group-one mask
  function automatic logic g1_hit(input logic [1:0] kind, input logic [2:0] cls, input logic req,
                                  input logic [7:0] um);
    logic hit;
    hit = 1'b0;
    if (um[UM_G1_SNP] && cls == CREM_CLS_SNP && kind != CREM_FLIT_IDLE) hit = 1'b1;
    if (cls == CREM_CLS_HOM && kind != CREM_FLIT_IDLE) begin
      if (um[UM_G1_HOMREQ] && req) hit = 1'b1;
      if (um[UM_G1_HOMNREQ] && !req) hit = 1'b1;
    end
    if (cls == CREM_CLS_DRS) begin
      if (um[UM_G1_DRSDATA] && kind == CREM_FLIT_DATA) hit = 1'b1;
      if (um[UM_G1_DRSHDR] && (kind == CREM_FLIT_HDR || kind == CREM_FLIT_PROT)) hit = 1'b1;
    end
    return hit;
  endfunction

  // Saturating sum of two hits
  function automatic logic [1:0] cap_sum(input logic a, input logic b, input logic [1:0] max_inc);
    logic [1:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > max_inc) ? max_inc : s;
  endfunction

  // One credit slot hits when its class bit is selected in the mask
  function automatic logic vn1_hit(input logic used, input logic [2:0] cls, input logic [7:0] um);
    return used && um[cls];
  endfunction

  // Per-cycle ceiling of each event
  function automatic logic [1:0] max_inc(input logic [7:0] ev);
    return (ev == EV_ADAPT_CRED || ev == EV_QUEUE_NE) ? MAX_INC_ONE : MAX_INC_TWO;
  endfunction

  // Event codes this monitor knows; anything else on an enabled counter raises the bad-event flag
  function automatic logic known_event(input logic [7:0] ev);
    logic ok;
    unique case (ev)
      EV_VN1_CREDIT, EV_ADAPT_CRED, EV_QUEUE_NE, EV_FLIT_G0, EV_FLIT_G1: ok = 1'b1;
      default:                                                          ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Link-side inputs registered once for timing; 80-bit flits already assembled from 20/10-bit units
  logic [1:0] valid_r;
  logic [3:0] kind_r;
  logic [5:0] cls_r;
  logic [1:0] req_r;
  logic [1:0] vn1_r;
  logic [5:0] vn1_cls_r;
  logic       adapt_r;
  logic       qne_r;

  // Flit lanes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      valid_r <= '0;
      kind_r  <= '0;
      cls_r   <= '0;
      req_r   <= '0;
    end else begin
      valid_r <= rx_flit_valid;
      kind_r  <= rx_flit_kind;
      cls_r   <= rx_flit_class;
      req_r   <= rx_flit_is_req;
    end
  end

  // Credit slots
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vn1_r     <= '0;
      vn1_cls_r <= '0;
      adapt_r   <= 1'b0;
    end else begin
      vn1_r     <= rx_vnet1_credit_used;
      vn1_cls_r <= rx_vnet1_credit_class;
      adapt_r   <= rx_adaptive_credit_used;
    end
  end

  // Queue occupancy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qne_r <= 1'b0;
    end else begin
      qne_r <= receive_flit_queue_nonempty;
    end
  end

  logic [1:0] inc_r [NUM_CNT];
  logic [1:0] inc_nxt [NUM_CNT];

  // Per-counter increment from the registered events
  always_comb begin
    logic [7:0] ev;
    logic [7:0] um;
    logic       h0;
    logic       h1;
    ev = '0;
    um = '0;
    h0 = 1'b0;
    h1 = 1'b0;
    for (int c = 0; c < NUM_CNT; c++) begin
      ev = cnt_event_sel[c*8 +: 8];
      um = cnt_unit_mask[c*8 +: 8];
      h0 = 1'b0;
      h1 = 1'b0;
      inc_nxt[c] = '0;
      if (cnt_enable[c]) begin
        unique case (ev)
          EV_VN1_CREDIT: begin
            h0 = vn1_hit(vn1_r[0], vn1_cls_r[2:0], um);
            h1 = vn1_hit(vn1_r[1], vn1_cls_r[5:3], um);
            inc_nxt[c] = cap_sum(h0, h1, max_inc(ev));
          end
          EV_ADAPT_CRED: begin
            inc_nxt[c] = cap_sum(adapt_r, 1'b0, max_inc(ev));
          end
          EV_QUEUE_NE: begin
            inc_nxt[c] = cap_sum(qne_r, 1'b0, max_inc(ev));
          end
          EV_FLIT_G0: begin
            h0 = valid_r[0] && g0_hit(kind_r[1:0], um);
            h1 = valid_r[1] && g0_hit(kind_r[3:2], um);
            inc_nxt[c] = cap_sum(h0, h1, max_inc(ev));
          end
          EV_FLIT_G1: begin
            h0 = valid_r[0] && g1_hit(kind_r[1:0], cls_r[2:0], req_r[0], um);
            h1 = valid_r[1] && g1_hit(kind_r[3:2], cls_r[5:3], req_r[1], um);
            inc_nxt[c] = cap_sum(h0, h1, max_inc(ev));
          end
          default: begin
            inc_nxt[c] = '0;
          end
        endcase
      end
    end
  end

  // Increments registered before they reach the counters
  always_ff @(posedge core_clk) begin
    for (int c = 0; c < NUM_CNT; c++) begin
      if (rst) begin
        inc_r[c] <= '0;
      end else begin
        inc_r[c] <= inc_nxt[c];
      end
    end
  end

  // Flags an enabled counter programmed with an event this monitor does not know
  always_ff @(posedge core_clk) begin
    for (int c = 0; c < NUM_CNT; c++) begin
      if (rst) begin
        cnt_bad_event_r[c] <= 1'b0;
      end else begin
        cnt_bad_event_r[c] <= cnt_enable[c] && !known_event(cnt_event_sel[c*8 +: 8]);
      end
    end
  end

  // All four counters accept every event here, so the 0..3 restriction always holds
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    crem_counter u_cnt (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (cnt_clear[g]),
      .inc      (inc_r[g]),
      .count    (cnt_value[g*CNT_W +: CNT_W])
    );
  end

endmodule
`default_nettype wire

// [crem_monitor_asserts.sv]
// Checker for the receive link event monitor, watching counter 0.
// Bound into crem_monitor; sees only its ports, one clock domain.
`default_nettype none
module crem_monitor_chk
  import crem_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire logic [1:0]               rx_flit_valid,
  input wire logic [3:0]               rx_flit_kind,
  input wire logic                     rx_adaptive_credit_used,
  input wire logic                     receive_flit_queue_nonempty,
  input wire logic [NUM_CNT*8-1:0]     cnt_event_sel,
  input wire logic [NUM_CNT*8-1:0]     cnt_unit_mask,
  input wire logic [NUM_CNT-1:0]       cnt_enable,
  input wire logic [NUM_CNT-1:0]       cnt_clear,
  input wire logic [NUM_CNT*CNT_W-1:0] cnt_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] live_r;
  logic [2:0] clr_r;
  wire [47:0] c0 = cnt_value[47:0];
  wire [7:0]  ev0 = cnt_event_sel[7:0];
  wire [7:0]  um0 = cnt_unit_mask[7:0];
  wire        calm = live_r == 3'h7 && clr_r == 3'h0 && !cnt_clear[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Edges since reset and recent clear history
  always_ff @(posedge core_clk) begin
    live_r <= rst ? 3'h0 : live_r + {2'h0, live_r != 3'h7};
    clr_r  <= {clr_r[1:0], cnt_clear[0]};
  end
  // Valid lanes carrying the given flit kind
  function automatic logic [1:0] nk(input logic [1:0] v, input logic [3:0] kd, input logic [1:0] k);
    nk = {1'b0, v[0] && kd[1:0] == k} + {1'b0, v[1] && kd[3:2] == k};
  endfunction
  // Count grows by the hits seen three edges earlier
  property inc_is(logic [7:0] e, logic [7:0] m, logic [1:0] d);
    calm && $past(ev0, 3) == e && $past(ev0) == e && $past(um0, 3) == m && $past(cnt_enable[0], 2)
      |-> c0 == $past(c0) + $past(d, 3);
  endproperty
  a_idle_flit_count:
    assert property (inc_is(8'h01, 8'h01, nk(rx_flit_valid, rx_flit_kind, 2'h0))) else $error("idle count off");
  a_data_flit_count:
    assert property (inc_is(8'h01, 8'h02, nk(rx_flit_valid, rx_flit_kind, 2'h2))) else $error("data count off");
  a_nondata_flit_count:
    assert property (inc_is(8'h01, 8'h04, nk(rx_flit_valid, rx_flit_kind, 2'h1) + nk(rx_flit_valid, rx_flit_kind,
      2'h3))) else $error("non-data count off");
  a_queue_busy_cycles:
    assert property (inc_is(8'h0A, 8'h00, {1'b0, receive_flit_queue_nonempty})) else $error("queue count off");
  a_adapt_credit_one:
    assert property (inc_is(8'h1D, 8'h00, {1'b0, rx_adaptive_credit_used})) else $error("adaptive count off");
  a_inc_cap_two:
    assert property (calm |-> c0 - $past(c0) <= 48'h2) else $error("increment above two");
  a_clear_holds_zero:
    assert property (cnt_clear[0] [*3] |=> c0 == 48'h0) else $error("count not held at zero");
  a_disabled_holds:
    assert property (calm && !$past(cnt_enable[0], 2) |-> $stable(c0)) else $error("disabled counter moved");
  cover property (ev0 == 8'h01 && c0 > 48'h8);
  cover property (ev0 == 8'h0A && receive_flit_queue_nonempty);
  cover property (cnt_clear[0] [*3]);
endmodule
bind crem_monitor crem_monitor_chk u_crem_monitor_chk (.core_clk, .rst, .rx_flit_valid, .rx_flit_kind,
  .rx_adaptive_credit_used, .receive_flit_queue_nonempty, .cnt_event_sel, .cnt_unit_mask, .cnt_enable,
  .cnt_clear, .cnt_value);
`default_nettype wire

// [crem_link_peer.sv]
// Far-end link sender: one cacheline per 16 cycles of a link-up window, idle flits otherwise.
// Samples up on the falling edge of core_clk and drives lanes on that edge.
`default_nettype none
module crem_link_peer
  import crem_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       up,
  output var  logic [1:0] valid,
  output var  logic [3:0] kind
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_r = 4'h0;
  initial begin
    valid = 2'h0;
    kind  = 4'h0;
  end
  always @(negedge core_clk) begin
    step_r <= up ? step_r + 4'h1 : 4'h0;
    valid  <= {2{up}};
    kind   <= {CREM_FLIT_IDLE, !up ? CREM_FLIT_IDLE : step_r == 4'h0 ? CREM_FLIT_HDR
               : step_r < 4'h9 ? CREM_FLIT_DATA : CREM_FLIT_IDLE};
  end
endmodule
`default_nettype wire

// [crem_monitor_bench.sv]
// Testbench for the receive link event monitor: four counters per test window.
// Drives inputs on the falling edge; the partner model supplies the flits.
`default_nettype none
module crem_monitor_bench
  import crem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     up = 1'b0, qne = 1'b0, adapt = 1'b0;
  logic [1:0]               valid, used = 2'h0, req = 2'h1;
  logic [3:0]               kind, bad, clr = 4'h0, en = 4'hF;
  logic [5:0]               cls = 6'h00;
  logic [31:0]              ev = 32'h0, um = 32'h0;
  logic [NUM_CNT*CNT_W-1:0] val;
  int                       errors = 0, n_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  crem_link_peer u_crem_link_peer (.core_clk, .up, .valid, .kind);
  crem_monitor u_crem_monitor (.core_clk, .rst, .rx_flit_valid(valid), .rx_flit_kind(kind), .rx_flit_class(cls),
    .rx_flit_is_req(req), .rx_vnet1_credit_used(used), .rx_vnet1_credit_class(6'h05),
    .rx_adaptive_credit_used(adapt), .receive_flit_queue_nonempty(qne), .cnt_event_sel(ev), .cnt_unit_mask(um),
    .cnt_enable(en), .cnt_clear(clr), .cnt_value(val), .cnt_bad_event_r(bad));
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One window: cacheline on lane 0, queue busy 5, adaptive 3, both credit slots 4 cycles
  task automatic run(input logic [31:0] e, m, input logic [2:0] c, input logic [31:0] x);
    int i;
    ev <= e;
    um <= m;
    cls <= {c, c};
    clr <= 4'hF;
    repeat (4) @(negedge core_clk);
    clr <= 4'h0;
    repeat (3) @(negedge core_clk);
    for (i = 0; i < 12; i++) begin
      up <= 1'b1;
      qne <= i < 5;
      adapt <= i < 3;
      used <= (i < 4) ? 2'h3 : 2'h0;
      @(negedge core_clk);
    end
    up <= 1'b0;
    qne <= 1'b0;
    adapt <= 1'b0;
    used <= 2'h0;
    repeat (8) @(negedge core_clk);
    for (i = 0; i < 4; i++) chk($sformatf("count%0d", i), val[i*48 +: 48], {40'h0, x[i*8 +: 8]});
    $display("test done events %h masks %h", e, m);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(negedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    run(32'h02010101, 32'h18040201, CREM_CLS_DRS, 32'h0901080F);
    run(32'h02391D0A, 32'h02200000, CREM_CLS_HOM, 32'h09040305);
    run(32'h1D390202, 32'h003F0601, CREM_CLS_SNP, 32'h03080009);
    run(32'h39020201, 32'h02100802, CREM_CLS_NCB, 32'h00000008);
    run(32'h0202391D, 32'h06040100, CREM_CLS_HOM, 32'h09000403);
    run(32'h02020A01, 32'h10080004, CREM_CLS_DRS, 32'h01080501);
    chk("bad event", {44'h0, bad}, 48'h0);
    en <= 4'hA;
    req <= 2'h0;
    run(32'h770A0277, 32'h00000400, CREM_CLS_HOM, 32'h00000900);
    chk("bad event", {44'h0, bad}, 48'h8);
    conclude();
  end
endmodule
`default_nettype wire
